//--- shared/vil_consts.svh
// Constants of the vectored interrupt logic: offsets, bits, resets.
// Included by the top module and the bench; holds definitions only.
`ifndef VIL_CONSTS_SVH
`define VIL_CONSTS_SVH

// Register indices; byte address is four times the index
`define VIL_IDX_TIMER0_STATUS_REG 8'h05
`define VIL_IDX_CORE_STATUS_REG 8'h06
`define VIL_IDX_MAIN_IRQ_STATUS_REG 8'h07
`define VIL_IDX_TMCFG 8'h08
`define VIL_IDX_PFLAG 8'h16
`define VIL_IDX_PEN 8'h17

// Peripheral flag and enable bit positions
`define VIL_PB_BIT 7
`define VIL_TMR3_BIT 6
`define VIL_TMR2_BIT 5
`define VIL_TMR1_BIT 4
`define VIL_CAP2_BIT 3
`define VIL_CAP1_BIT 2
`define VIL_TX_BIT 1
`define VIL_RX_BIT 0

// Main status bits
`define VIL_PERIPH_SUMMARY_FLAG_BIT 7
`define VIL_TIMER0_CLKPIN_FLAG_BIT 6
`define VIL_TIMER0_OVERFLOW_FLAG_BIT 5
`define VIL_EXT_PIN_FLAG_BIT 4
`define VIL_PERIPH_GROUP_ENABLE_BIT 3
`define VIL_TIMER0_CLKPIN_ENABLE_BIT 2
`define VIL_TIMER0_OVERFLOW_ENABLE_BIT 1
`define VIL_INTE_BIT 0

// Other control bits
`define VIL_GLOBAL_IRQ_DISABLE_BIT 4
`define VIL_EXT_PIN_EDGE_SELECT_BIT 7
`define VIL_TIMER0_CLKPIN_EDGE_SELECT_BIT 6
`define VIL_T16_BIT 0
`define VIL_CA1PR3_BIT 1

// Reset values
`define VIL_PEN_RST 8'h00
`define VIL_PFLAG_RST 8'h02
`define VIL_MAIN_IRQ_STATUS_REG_RST 8'h00
`define VIL_TIMER0_STATUS_REG_RST 2'h0
`define VIL_TMCFG_RST 2'h0

// Vectors and timer0 limits
`define VIL_VEC_EXT 16'h0008
`define VIL_VEC_T0 16'h0010
`define VIL_VEC_CK 16'h0018
`define VIL_VEC_PERI 16'h0020
`define VIL_T0_MAX 16'hFFFF
`define VIL_T0_ZERO 16'h0000

// Core clocks per instruction cycle, minus one
`define VIL_Q_LAST 2'h3

`endif

//--- shared/vil_pkg.sv
// Types of the vectored interrupt logic.
// Offsets and bit positions live in vil_consts.svh.
package vil_pkg;

  typedef struct packed {
    logic t3_ovf;
    logic t3_per_roll;
    logic t2_per_roll;
    logic t1_per_roll8;
    logic t12_per_roll16;
    logic cap2;
    logic cap1;
    logic tx_empty;
    logic rx_full;
  } vil_pev_s;

  typedef enum logic [2:0] {
    VIL_SRC_NONE,
    VIL_SRC_EXT,
    VIL_SRC_T0,
    VIL_SRC_CK,
    VIL_SRC_PERI
  } vil_src_e;

endpackage

//--- hdl/vil_edge_det.sv
// Selectable edge detector for a pin sampled on the core clock.
// Assumes the pin is already synchronous to core_clk.
`timescale 1ns/1ps
module vil_edge_det (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Pin and edge choice
  input wire logic pin,
  input wire logic rise_sel,
  output logic hit
);
  logic prev_q;
  logic armed_q;

  // Plain data, no reset needed
  always_ff @(posedge core_clk) begin
    prev_q <= pin;
  end

  // No edge before one real sample, so a static pin is no event
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      armed_q <= 1'b0;
    end else begin
      armed_q <= 1'b1;
    end
  end

  assign hit = armed_q & (rise_sel ? (pin & ~prev_q) : (~pin & prev_q));
endmodule

//--- hdl/vil_top.sv
// Vectored interrupt logic: flags, enables, global disable, vectors.
// Assumes an APB master on core_clk, synchronous pin inputs and a core
// that pushes the return address and loads the PC on irq_ack.
//
// Operation
// R01: Enable register holds eight peripheral enables.
// R02: Flags set regardless of enables or disable.
// R03: Port change flag follows port mismatch.
// R04: Timer3 flag by overflow or period rollover.
// R05: Timer2 flag on period rollover.
// R06: Timer1 flag, 8-bit or joined 16-bit.
// R07: Capture flags set on capture events.
// R08: Transmit and receive flags are read-only levels.
// R09: Global disable bit blocks all interrupts.
// R10: Peripheral needs group enable and own enable.
// R11: Reset sets the global disable.
// R12: Accept sets disable, pushes, loads vector.
// R13: Return clears the global disable.
// R14: Vectors 0008h, 0010h, 0018h for direct sources.
// R15: Peripheral vector 0020h, lowest fixed priority.
// R16: Software clears peripheral flags before return.
// R17: Software disables globally before clearing enables.
// R18: External pin edge sets its flag.
// R19: Timer0 wrap sets overflow flag.
// R20: Timer0 clock pin edge sets flag.
// R21: Pin and peripheral interrupts raise wake.
// R22: Summary flag is OR of enabled flags.
// R23: Direct flags clear on vectoring, peripheral not.
// R24: Request only when enabled, pending, not disabled.
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`include "vil_consts.svh"
module vil_top (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins
  input wire logic ext_irq_pin,
  input wire logic timer0_clock_pin,
  input wire logic [7:0] portb_pins,
  // Peripheral events
  input wire logic [15:0] timer0,
  input wire vil_pkg::vil_pev_s pev,
  input wire logic portb_read,
  // Processor core
  input wire logic irq_ack,
  input wire logic return_from_irq,
  output logic irq_req,
  output logic [15:0] irq_vector,
  output logic wake,
  // Timer configuration
  output logic timer1_wide_mode,
  output logic capture1_or_period3_select
);

  function automatic logic hit_reg(input logic [11:0] a,
                                   input logic [7:0] idx);
    hit_reg = (a == {2'b00, idx, 2'b00});
  endfunction

  function automatic vil_pkg::vil_src_e pick_src(input logic [3:0] p);
    if (p[0]) begin
      pick_src = vil_pkg::VIL_SRC_EXT;
    end else if (p[1]) begin
      pick_src = vil_pkg::VIL_SRC_T0;
    end else if (p[2]) begin
      pick_src = vil_pkg::VIL_SRC_CK;
    end else if (p[3]) begin
      pick_src = vil_pkg::VIL_SRC_PERI;
    end else begin
      pick_src = vil_pkg::VIL_SRC_NONE;
    end
  endfunction

  function automatic logic [15:0] vec_of(input vil_pkg::vil_src_e s);
    unique case (s)
      vil_pkg::VIL_SRC_EXT: vec_of = `VIL_VEC_EXT;
      vil_pkg::VIL_SRC_T0: vec_of = `VIL_VEC_T0;
      vil_pkg::VIL_SRC_CK: vec_of = `VIL_VEC_CK;
      vil_pkg::VIL_SRC_PERI: vec_of = `VIL_VEC_PERI;
      default: vec_of = `VIL_VEC_PERI;
    endcase
  endfunction

  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic [7:0] pen_q;
  logic [7:0] pflag_q;
  logic [7:0] main_irq_status_reg_q;
  logic [7:0] main_irq_status_reg_d;
  logic global_irq_disable_q;
  logic [1:0] timer0_status_reg_q;
  logic [1:0] tmcfg_q;
  logic [15:0] t0_prev_q;
  logic [7:0] pb_latch_q;
  logic pb_armed_q;
  logic [1:0] q_cnt_q;
  logic tick_q;
  logic irq_req_q;
  logic [15:0] irq_vector_q;
  vil_pkg::vil_src_e sel_q;
  logic wake_q;
  logic [7:0] rd_mux;
  logic mapped;
  logic wr_done;
  logic take;
  logic ext_hit;
  logic ck_hit;
  logic t0_hit;
  logic t3_hit;
  logic t1_hit;
  logic pb_mismatch;
  logic [7:2] pset;
  logic periph_summary_flag;
  logic ext_pend;
  logic t0_pend;
  logic ck_pend;
  logic pe_pend;

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq_req = irq_req_q;
  assign irq_vector = irq_vector_q;
  assign wake = wake_q;
  assign timer1_wide_mode = tmcfg_q[`VIL_T16_BIT];
  assign capture1_or_period3_select = tmcfg_q[`VIL_CA1PR3_BIT];

  // Register bus
  assign wr_done = psel & penable & pready_q & pwrite;

  always_comb begin
    rd_mux = 8'h00;
    mapped = 1'b1;
    if (hit_reg(paddr, `VIL_IDX_PFLAG)) begin
      rd_mux = pflag_q;
    end else if (hit_reg(paddr, `VIL_IDX_PEN)) begin
      rd_mux = pen_q;
    end else if (hit_reg(paddr, `VIL_IDX_MAIN_IRQ_STATUS_REG)) begin
      rd_mux = {periph_summary_flag, main_irq_status_reg_q[6:0]};
    end else if (hit_reg(paddr, `VIL_IDX_CORE_STATUS_REG)) begin
      rd_mux = {3'h0, global_irq_disable_q, 4'h0};
    end else if (hit_reg(paddr, `VIL_IDX_TIMER0_STATUS_REG)) begin
      rd_mux = {timer0_status_reg_q, 6'h00};
    end else if (hit_reg(paddr, `VIL_IDX_TMCFG)) begin
      rd_mux = {6'h00, tmcfg_q};
    end else begin
      mapped = 1'b0;
    end
  end

  // Zero wait states: ready rises for the access phase after setup
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else if (psel & ~penable) begin
      pready_q <= 1'b1;
      pslverr_q <= ~mapped;
      prdata_q <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_mux};
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  // Plain control registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pen_q <= `VIL_PEN_RST;
      timer0_status_reg_q <= `VIL_TIMER0_STATUS_REG_RST;
      tmcfg_q <= `VIL_TMCFG_RST;
    end else begin
      if (wr_done & hit_reg(paddr, `VIL_IDX_PEN)) begin
        pen_q <= pwdata[7:0]; // [R01]
      end
      if (wr_done & hit_reg(paddr, `VIL_IDX_TIMER0_STATUS_REG)) begin
        timer0_status_reg_q <= pwdata[7:6];
      end
      if (wr_done & hit_reg(paddr, `VIL_IDX_TMCFG)) begin
        tmcfg_q <= pwdata[1:0];
      end
    end
  end

  // Instruction cycle divider
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      q_cnt_q <= 2'h0;
      tick_q <= 1'b0;
    end else begin
      q_cnt_q <= q_cnt_q + 2'h1;
      tick_q <= (q_cnt_q == `VIL_Q_LAST);
    end
  end

  // Direct source events
  vil_edge_det u_ext_edge (
    .core_clk(core_clk),
    .rst(rst),
    .pin(ext_irq_pin),
    .rise_sel(timer0_status_reg_q[`VIL_EXT_PIN_EDGE_SELECT_BIT - 6]),
    .hit(ext_hit)
  ); // [R18]

  vil_edge_det u_ck_edge (
    .core_clk(core_clk),
    .rst(rst),
    .pin(timer0_clock_pin),
    .rise_sel(timer0_status_reg_q[`VIL_TIMER0_CLKPIN_EDGE_SELECT_BIT - 6]),
    .hit(ck_hit)
  ); // [R20]

  always_ff @(posedge core_clk) begin
    t0_prev_q <= timer0;
  end

  assign t0_hit = (t0_prev_q == `VIL_T0_MAX) &
                  (timer0 == `VIL_T0_ZERO); // [R19]

  // Port change: latch refreshed when the core reads the port
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pb_latch_q <= 8'h00;
      pb_armed_q <= 1'b0;
    end else if (~pb_armed_q | portb_read) begin
      pb_latch_q <= portb_pins;
      pb_armed_q <= 1'b1;
    end
  end

  assign pb_mismatch = pb_armed_q & (portb_pins != pb_latch_q); // [R03]

  // Peripheral flag sources
  assign t3_hit = tmcfg_q[`VIL_CA1PR3_BIT] ? pev.t3_ovf
                                          : pev.t3_per_roll; // [R04]
  assign t1_hit = tmcfg_q[`VIL_T16_BIT] ? pev.t12_per_roll16
                                       : pev.t1_per_roll8; // [R06]
  assign pset = {pb_mismatch, t3_hit, pev.t2_per_roll, t1_hit,
                 pev.cap2, pev.cap1}; // [R05] [R07]

  // Set wins over a software clear in the same cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pflag_q <= `VIL_PFLAG_RST;
    end else begin
      if (wr_done & hit_reg(paddr, `VIL_IDX_PFLAG)) begin
        pflag_q[7:2] <= pwdata[7:2] | pset; // [R02]
      end else begin
        pflag_q[7:2] <= pflag_q[7:2] | pset; // [R02]
      end
      pflag_q[`VIL_TX_BIT] <= pev.tx_empty; // [R08]
      pflag_q[`VIL_RX_BIT] <= pev.rx_full; // [R08]
    end
  end

  assign periph_summary_flag = |(pflag_q & pen_q); // [R22]

  // Main status flags and enables
  assign take = irq_ack & irq_req_q;

  always_comb begin
    main_irq_status_reg_d = main_irq_status_reg_q;
    if (wr_done & hit_reg(paddr, `VIL_IDX_MAIN_IRQ_STATUS_REG)) begin
      main_irq_status_reg_d[6:0] = pwdata[6:0];
    end
    if (take) begin
      // Peripheral sources stay pending until software clears them
      unique case (sel_q)
        vil_pkg::VIL_SRC_EXT: main_irq_status_reg_d[`VIL_EXT_PIN_FLAG_BIT] = 1'b0; // [R23]
        vil_pkg::VIL_SRC_T0: main_irq_status_reg_d[`VIL_TIMER0_OVERFLOW_FLAG_BIT] = 1'b0; // [R23]
        vil_pkg::VIL_SRC_CK: main_irq_status_reg_d[`VIL_TIMER0_CLKPIN_FLAG_BIT] = 1'b0; // [R23]
        vil_pkg::VIL_SRC_PERI: main_irq_status_reg_d[7] = 1'b0; // [R16] [R23]
        vil_pkg::VIL_SRC_NONE: main_irq_status_reg_d[7] = 1'b0;
      endcase
    end
    if (ext_hit) begin
      main_irq_status_reg_d[`VIL_EXT_PIN_FLAG_BIT] = 1'b1; // [R02] [R18]
    end
    if (t0_hit) begin
      main_irq_status_reg_d[`VIL_TIMER0_OVERFLOW_FLAG_BIT] = 1'b1; // [R02] [R19]
    end
    if (ck_hit) begin
      main_irq_status_reg_d[`VIL_TIMER0_CLKPIN_FLAG_BIT] = 1'b1; // [R02] [R20]
    end
    main_irq_status_reg_d[7] = 1'b0;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      main_irq_status_reg_q <= `VIL_MAIN_IRQ_STATUS_REG_RST;
    end else begin
      main_irq_status_reg_q <= main_irq_status_reg_d;
    end
  end

  // Global disable: accept beats return, return beats a write
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      global_irq_disable_q <= 1'b1; // [R11]
    end else if (take) begin
      global_irq_disable_q <= 1'b1; // [R12]
    end else if (return_from_irq) begin
      global_irq_disable_q <= 1'b0; // [R13]
    end else if (wr_done & hit_reg(paddr, `VIL_IDX_CORE_STATUS_REG)) begin
      global_irq_disable_q <= pwdata[`VIL_GLOBAL_IRQ_DISABLE_BIT];
    end
  end

  // Pending sources
  assign ext_pend = main_irq_status_reg_q[`VIL_EXT_PIN_FLAG_BIT] & main_irq_status_reg_q[`VIL_INTE_BIT];
  assign t0_pend = main_irq_status_reg_q[`VIL_TIMER0_OVERFLOW_FLAG_BIT] & main_irq_status_reg_q[`VIL_TIMER0_OVERFLOW_ENABLE_BIT];
  assign ck_pend = main_irq_status_reg_q[`VIL_TIMER0_CLKPIN_FLAG_BIT] & main_irq_status_reg_q[`VIL_TIMER0_CLKPIN_ENABLE_BIT];
  assign pe_pend = periph_summary_flag & main_irq_status_reg_q[`VIL_PERIPH_GROUP_ENABLE_BIT]; // [R10]

  // Request, evaluated once per instruction cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_req_q <= 1'b0;
      irq_vector_q <= `VIL_VEC_PERI;
      sel_q <= vil_pkg::VIL_SRC_NONE;
    end else if (take) begin
      irq_req_q <= 1'b0; // [R12]
      sel_q <= vil_pkg::VIL_SRC_NONE;
    end else if (global_irq_disable_q) begin
      // Drop at once, so no stale request survives a disable
      irq_req_q <= 1'b0; // [R09]
      sel_q <= vil_pkg::VIL_SRC_NONE;
    end else if (tick_q) begin
      irq_req_q <= ext_pend | t0_pend | ck_pend | pe_pend; // [R24]
      sel_q <= pick_src({pe_pend, ck_pend, t0_pend, ext_pend}); // [R15]
      irq_vector_q <= vec_of(
        pick_src({pe_pend, ck_pend, t0_pend, ext_pend})); // [R14]
    end
  end

  // Wake does not depend on the global disable
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= ext_pend | ck_pend | pe_pend; // [R21]
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  sequence s_take;
    irq_ack && irq_req_q;
  endsequence

  sequence s_after_take;
    ##1 (global_irq_disable_q && !irq_req_q);
  endsequence

  property p_take;
    s_take |-> s_after_take;
  endproperty
  a_take: assert property (p_take) // [R12]
    else $error("accept did not disable and drop request");

  property p_return;
    return_from_irq && !take |=> !global_irq_disable_q;
  endproperty
  a_return: assert property (p_return) // [R13]
    else $error("return did not clear global disable");

  property p_blocked;
    global_irq_disable_q && !irq_req_q |=> !irq_req_q;
  endproperty
  a_blocked: assert property (p_blocked) // [R09]
    else $error("request raised while globally disabled");

  property p_ext_first;
    tick_q && !global_irq_disable_q && !take && ext_pend
      |=> irq_req_q && irq_vector_q == `VIL_VEC_EXT;
  endproperty
  a_ext_first: assert property (p_ext_first) // [R15]
    else $error("external pin did not win priority");

  property p_peri_vec;
    tick_q && !global_irq_disable_q && !take && pe_pend && !ext_pend && !t0_pend
      && !ck_pend |=> irq_req_q && irq_vector_q == `VIL_VEC_PERI;
  endproperty
  a_peri_vec: assert property (p_peri_vec) // [R15]
    else $error("peripheral vector wrong");

  property p_summary;
    psel && !penable && !pwrite && hit_reg(paddr, `VIL_IDX_MAIN_IRQ_STATUS_REG)
      |=> prdata_q[`VIL_PERIPH_SUMMARY_FLAG_BIT] == $past(|(pflag_q & pen_q));
  endproperty
  a_summary: assert property (p_summary) // [R22]
    else $error("summary flag read wrong");

  property p_ext_edge;
    !$past(rst) && timer0_status_reg_q[1] && ext_irq_pin && !$past(ext_irq_pin)
      |=> main_irq_status_reg_q[`VIL_EXT_PIN_FLAG_BIT];
  endproperty
  a_ext_edge: assert property (p_ext_edge) // [R18]
    else $error("rising pin edge did not set flag");

  property p_t0_wrap;
    !$past(rst) && $past(timer0) == `VIL_T0_MAX
      && timer0 == `VIL_T0_ZERO |=> main_irq_status_reg_q[`VIL_TIMER0_OVERFLOW_FLAG_BIT];
  endproperty
  a_t0_wrap: assert property (p_t0_wrap) // [R19]
    else $error("timer0 wrap did not set flag");

  property p_t2_flag;
    pev.t2_per_roll |=> pflag_q[`VIL_TMR2_BIT] [*2];
  endproperty
  a_t2_flag: assert property (p_t2_flag) // [R05]
    else $error("timer2 flag not set and held");

endmodule

//--- verification/vil_core_model.sv
// Behavioural processor core facing the vectored interrupt logic.
// Assumes a single core clock; the bench enables acks and sets delay.
`timescale 1ns/1ps
module vil_core_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Vector request from the interrupt logic
  input wire logic irq_req,
  input wire logic [15:0] irq_vector,
  output logic irq_ack,
  output logic return_from_irq,
  // Bench control and observation
  input wire logic ack_en,
  input wire logic [3:0] ack_dly,
  input wire logic ret_cmd,
  output logic [15:0] last_vec,
  output logic [7:0] ack_cnt
);
  logic [3:0] wait_q;

  // Ack only a standing request; vector sampled at the ack
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_ack <= 1'b0;
      wait_q <= 4'h0;
      last_vec <= 16'h0000;
      ack_cnt <= 8'h00;
    end else begin
      irq_ack <= 1'b0;
      if (irq_req && ack_en && !irq_ack) begin
        if (wait_q == ack_dly) begin
          irq_ack <= 1'b1;
          last_vec <= irq_vector;
          ack_cnt <= ack_cnt + 8'h01;
          wait_q <= 4'h0;
        end else begin
          wait_q <= wait_q + 4'h1;
        end
      end else begin
        wait_q <= 4'h0;
      end
    end
  end

  // Return pulse issued by the service routine's last instruction
  assign return_from_irq = ret_cmd;
endmodule

//--- verification/vil_top_tb_top.sv
// Self-checking bench of the vectored interrupt logic over APB.
// Assumes the core model in vil_core_model.sv and zero-wait APB.
`timescale 1ns/1ps
`include "vil_consts.svh"
module vil_top_tb_top;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err_seen, tm_wide, tm_sel;
  logic ext_pin = 1'b0, ck_pin = 1'b1, portb_read = 1'b0;
  logic [7:0] portb = 8'h00, ack_cnt;
  logic [15:0] timer0 = 16'h0000, irq_vector, last_vec;
  logic [8:0] pev_v = 9'h002;
  logic irq_ack, ret, irq_req, wake, ack_en = 1'b0, ret_cmd = 1'b0;
  logic [3:0] ack_dly = 4'h0;
  logic [31:0] vecs [4] = '{32'h8, 32'h10, 32'h18, 32'h20};
  logic [7:0] stas [4] = '{8'hEF, 8'hCF, 8'h8F, 8'h8F};
  int bad_count = 0, samples_checked = 0, cycles = 0;

  always #5 core_clk = ~core_clk;

  vil_top dut (.core_clk(core_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_irq_pin(ext_pin), .timer0_clock_pin(ck_pin),
    .portb_pins(portb), .timer0(timer0),
    .pev(vil_pkg::vil_pev_s'(pev_v)), .portb_read(portb_read),
    .irq_ack(irq_ack), .return_from_irq(ret), .irq_req(irq_req),
    .irq_vector(irq_vector), .wake(wake), .timer1_wide_mode(tm_wide),
    .capture1_or_period3_select(tm_sel));

  vil_core_model core (.core_clk(core_clk), .rst(rst),
    .irq_req(irq_req), .irq_vector(irq_vector), .irq_ack(irq_ack),
    .return_from_irq(ret), .ack_en(ack_en), .ack_dly(ack_dly),
    .ret_cmd(ret_cmd), .last_vec(last_vec), .ack_cnt(ack_cnt));

  task automatic test_done();
    $display("Compared %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Generous ceiling; the sequence needs well under 2000 cycles
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      test_done();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One transfer plus an idle cycle, so psel never toggles twice at once
  task automatic apb(input logic w, input logic [7:0] idx,
                     input logic [7:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    // Ready looked at mid-cycle, where it has settled
    @(negedge core_clk);
    while (pready !== 1'b1 && n < 50) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 50) begin
      bad_count++;
    end
    rd = prdata;
    err_seen = pslverr;
    @(posedge core_clk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp,
                     input string what);
    apb(1'b0, idx, 8'h00);
    chk(what, {24'h0, exp}, rd);
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
  endtask

  // Flags cleared, one event pulsed, flag register read back
  task automatic ev(input int b, input logic [7:0] cfg,
                    input logic [7:0] exp);
    wr(`VIL_IDX_TMCFG, cfg);
    wr(`VIL_IDX_PFLAG, 8'h00);
    pev_v <= 9'h002 | (9'h001 << b);
    @(posedge core_clk);
    pev_v <= 9'h002;
    @(posedge core_clk);
    rdc(`VIL_IDX_PFLAG, exp, "pflag event");
  endtask

  initial begin
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rdc(`VIL_IDX_CORE_STATUS_REG, 8'h10, "core_status_reg reset");
    rdc(`VIL_IDX_PEN, 8'h00, "pen reset");
    rdc(`VIL_IDX_PFLAG, 8'h02, "pflag reset");
    rdc(`VIL_IDX_MAIN_IRQ_STATUS_REG, 8'h00, "main_irq_status_reg reset");
    rdc(8'hF0, 8'h00, "unmapped data");
    chk("unmapped error", 32'h1, {31'h0, err_seen});
    wr(`VIL_IDX_PEN, 8'hA5);
    rdc(`VIL_IDX_PEN, 8'hA5, "pen rw");
    wr(`VIL_IDX_PEN, 8'h00);
    ev(8, 8'h02, 8'h42);
    chk("period3 select", 32'h1, {31'h0, tm_sel});
    ev(7, 8'h02, 8'h02);
    ev(7, 8'h00, 8'h42);
    ev(6, 8'h00, 8'h22);
    ev(5, 8'h00, 8'h12);
    ev(4, 8'h00, 8'h02);
    ev(4, 8'h01, 8'h12);
    chk("wide mode", 32'h1, {31'h0, tm_wide});
    ev(3, 8'h00, 8'h0A);
    ev(2, 8'h00, 8'h06);
    pev_v <= 9'h001;
    cyc(2);
    wr(`VIL_IDX_PFLAG, 8'hFF);
    rdc(`VIL_IDX_PFLAG, 8'hFD, "pflag ro bits");
    pev_v <= 9'h002;
    wr(`VIL_IDX_PFLAG, 8'h04);
    wr(`VIL_IDX_PEN, 8'h04);
    rdc(`VIL_IDX_MAIN_IRQ_STATUS_REG, 8'h80, "summary set");
    wr(`VIL_IDX_PEN, 8'h08);
    rdc(`VIL_IDX_MAIN_IRQ_STATUS_REG, 8'h00, "summary masked");
    portb <= 8'h5A;
    cyc(2);
    wr(`VIL_IDX_PFLAG, 8'h00);
    rdc(`VIL_IDX_PFLAG, 8'h82, "mismatch held");
    portb_read <= 1'b1;
    @(posedge core_clk);
    portb_read <= 1'b0;
    wr(`VIL_IDX_PFLAG, 8'h00);
    rdc(`VIL_IDX_PFLAG, 8'h02, "mismatch ended");
    // All four sources pending while globally disabled
    wr(`VIL_IDX_TIMER0_STATUS_REG, 8'h80);
    wr(`VIL_IDX_PEN, 8'h04);
    wr(`VIL_IDX_PFLAG, 8'h04);
    wr(`VIL_IDX_MAIN_IRQ_STATUS_REG, 8'h0F);
    ext_pin <= 1'b1;
    ck_pin <= 1'b0;
    timer0 <= 16'hFFFF;
    @(posedge core_clk);
    timer0 <= 16'h0000;
    cyc(8);
    chk("irq while disabled", 32'h0, {31'h0, irq_req});
    chk("wake pending", 32'h1, {31'h0, wake});
    rdc(`VIL_IDX_MAIN_IRQ_STATUS_REG, 8'hFF, "all pending");
    ack_en <= 1'b1;
    wr(`VIL_IDX_CORE_STATUS_REG, 8'h00);
    for (int k = 0; k < 4; k++) begin
      for (int n = 0; n < 40 && ack_cnt == 8'(k); n++) begin
        @(posedge core_clk);
      end
      chk("vector", vecs[k], {16'h0, last_vec});
      rdc(`VIL_IDX_CORE_STATUS_REG, 8'h10, "disable on accept");
      rdc(`VIL_IDX_MAIN_IRQ_STATUS_REG, stas[k], "flags after vector");
      if (k == 3) begin
        rdc(`VIL_IDX_PFLAG, 8'h06, "periph kept");
        wr(`VIL_IDX_PFLAG, 8'h00);
      end
      ack_dly <= 4'(k);
      ret_cmd <= 1'b1;
      @(posedge core_clk);
      ret_cmd <= 1'b0;
    end
    cyc(12);
    chk("no request left", 32'h4, {24'h0, ack_cnt});
    rdc(`VIL_IDX_CORE_STATUS_REG, 8'h00, "return enables");
    // Group enable off: peripheral stays masked
    wr(`VIL_IDX_CORE_STATUS_REG, 8'h10);
    wr(`VIL_IDX_MAIN_IRQ_STATUS_REG, 8'h07);
    wr(`VIL_IDX_PFLAG, 8'h04);
    wr(`VIL_IDX_CORE_STATUS_REG, 8'h00);
    cyc(12);
    chk("group masked", 32'h4, {24'h0, ack_cnt});
    test_done();
  end
endmodule
